/* hw/ltm_pkg.sv */
// Purpose: shared constants for the led temperature measure control block
// Assumes: 8-bit register interface, sys_clk at 250 MHz
// Notes: offsets are the documented register addresses
package ltm_pkg;
  // register addresses on the control bus
  localparam logic [7:0] ADDR_CTRL = 8'h3e;
  localparam logic [7:0] ADDR_INT_RESULT = 8'h3f;
  localparam logic [7:0] ADDR_EXT_INPUT = 8'h40;
  // control field positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_ENABLE = 2;
  localparam int BIT_REPEAT = 1;
  localparam int BIT_SRC_SEL = 0;
  // reset values
  localparam logic [7:0] RST_INT_RESULT = 8'h19;
  localparam logic [7:0] RST_EXT_INPUT = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // compensation range limits, signed degrees
  localparam logic signed [7:0] TEMP_MAX = 8'sh59;
  localparam logic signed [7:0] TEMP_MIN = 8'shda;
  // nominal conversion time at room temperature
  localparam int CONV_TIME_MS = 20;
  localparam int CLK_MHZ = 250;
  localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLK_MHZ;
  // conversion engine states
  typedef enum logic [0:0] {LTM_IDLE, LTM_CONV} ltm_state_e;
endpackage

/* hw/led_temp_measure_control.sv */
// Purpose: temperature conversion control, result and compensation select
// Assumes: host reaches registers through a byte-wide read/write port
// Notes: sensor conversion timing comes from sensorDone when USE_SENSOR_DONE is set, else from the cycle counter
`timescale 1ns/1ps
`default_nettype none
module led_temp_measure_control
  import ltm_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES,
  parameter bit USE_SENSOR_DONE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  // register port, same clock domain
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // power save state from the device mode logic
  input wire logic powerSave,
  // analog sensor interface
  input wire logic sensorDone,
  input wire logic [7:0] sensorValue,
  output logic sensorEnable,
  // compensation feed
  output logic [7:0] compTemp
);

  localparam int CW = $clog2(CONV_CYCLES_P + 1);

  // elaboration check on the counter
  if (CONV_CYCLES_P < 1) begin : g_chk
    $error("CONV_CYCLES_P must be at least 1");
  end

  // clamp a signed value to the compensation range
  function automatic logic [7:0] clampTemp(input logic [7:0] v);
    logic signed [7:0] s;
    s = v;
    if (s > TEMP_MAX) begin
      clampTemp = TEMP_MAX;
    end else if (s < TEMP_MIN) begin
      clampTemp = TEMP_MIN;
    end else begin
      clampTemp = v;
    end
  endfunction

  // two-flop sync of sensor pins, they come from the analog side
  logic [1:0] doneSync_reg;
  logic [7:0] valMeta_reg;
  logic [7:0] valSync_reg;
  logic psMeta_reg;
  logic psSync_reg;
  logic psLast_reg;

  // synchronisers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      doneSync_reg <= 2'h0;
      valMeta_reg <= 8'h00;
      valSync_reg <= 8'h00;
      psMeta_reg <= 1'b0;
      psSync_reg <= 1'b0;
      psLast_reg <= 1'b0;
    end else begin
      doneSync_reg <= {doneSync_reg[0], sensorDone};
      valMeta_reg <= sensorValue;
      valSync_reg <= valMeta_reg;
      psMeta_reg <= powerSave;
      psSync_reg <= psMeta_reg;
      psLast_reg <= psSync_reg;
    end
  end

  logic doneSeen;
  assign doneSeen = doneSync_reg[1];

  // register state
  logic enable_reg, enable_next;
  logic repeat_reg, repeat_next;
  logic srcSel_reg, srcSel_next;
  logic [7:0] intResult_reg, intResult_next;
  logic [7:0] extInput_reg, extInput_next;
  logic startup_reg, startup_next;
  ltm_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic [7:0] rdData_reg, rdData_next;
  logic rdValid_reg, rdValid_next;
  logic [7:0] comp_reg, comp_next;
  logic sensEn_reg, sensEn_next;

  logic ctrlWrite;
  logic finish;
  logic exitPs;
  logic startReq;

  // next-state logic for registers and conversion engine
  always_comb begin
    enable_next = enable_reg;
    repeat_next = repeat_reg;
    srcSel_next = srcSel_reg;
    intResult_next = intResult_reg;
    extInput_next = extInput_reg;
    startup_next = 1'b0;
    state_next = state_reg;
    cnt_next = cnt_reg;
    rdData_next = rdData_reg;
    rdValid_next = 1'b0;
    ctrlWrite = regWrEn && (regAddr == ADDR_CTRL);
    exitPs = psLast_reg && !psSync_reg;
    finish = 1'b0;
    startReq = 1'b0;

    // control writes
    if (ctrlWrite) begin
      enable_next = regWrData[BIT_ENABLE];
      repeat_next = regWrData[BIT_REPEAT];
      srcSel_next = regWrData[BIT_SRC_SEL];
    end
    // external temperature, clamped on write
    if (regWrEn && (regAddr == ADDR_EXT_INPUT)) begin
      extInput_next = clampTemp(regWrData);
    end
    // writes to the result address are ignored

    // start conditions
    if (ctrlWrite && regWrData[BIT_ENABLE]) begin
      startReq = 1'b1;
    end
    if (enable_next && (startup_reg || exitPs)) begin
      startReq = 1'b1;
    end

    // conversion engine
    case (state_reg)
      LTM_IDLE: begin
        if (enable_next && repeat_next && !psSync_reg) begin
          startReq = 1'b1;
        end
      end
      LTM_CONV: begin
        if (!enable_next) begin
          state_next = LTM_IDLE;
        end else if (USE_SENSOR_DONE ? doneSeen
                     : (cnt_reg == CW'(CONV_CYCLES_P - 1))) begin
          finish = 1'b1;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      default: begin
        state_next = LTM_IDLE;
      end
    endcase

    if (finish) begin
      intResult_next = valSync_reg;
      state_next = LTM_IDLE;
      if (repeat_next && !psSync_reg) begin
        startReq = 1'b1;
      end
    end
    if (psSync_reg && repeat_next && !(ctrlWrite && regWrData[BIT_ENABLE])) begin
      // repeat mode suspended in power save
      startReq = startReq && (startup_reg || exitPs);
    end
    if (startReq && enable_next) begin
      state_next = LTM_CONV;
      cnt_next = '0;
    end
    busy_next = (state_next == LTM_CONV);

    // read path
    if (regRdEn) begin
      rdValid_next = 1'b1;
      case (regAddr)
        ADDR_CTRL: begin
          rdData_next = ZERO_BYTE;
          rdData_next[BIT_BUSY] = busy_reg;
          rdData_next[BIT_ENABLE] = enable_reg;
          rdData_next[BIT_REPEAT] = repeat_reg;
          rdData_next[BIT_SRC_SEL] = srcSel_reg;
        end
        ADDR_INT_RESULT: begin
          rdData_next = intResult_reg;
        end
        ADDR_EXT_INPUT: begin
          rdData_next = extInput_reg;
        end
        default: begin
          rdData_next = ZERO_BYTE;
        end
      endcase
    end

    // compensation source
    comp_next = srcSel_next ? extInput_next : intResult_next;
    sensEn_next = enable_next;
  end

  // register stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_reg <= 1'b0;
      repeat_reg <= 1'b0;
      srcSel_reg <= 1'b0;
      intResult_reg <= RST_INT_RESULT;
      extInput_reg <= RST_EXT_INPUT;
      startup_reg <= 1'b1;
      state_reg <= LTM_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      rdData_reg <= ZERO_BYTE;
      rdValid_reg <= 1'b0;
      comp_reg <= RST_INT_RESULT;
      sensEn_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      repeat_reg <= repeat_next;
      srcSel_reg <= srcSel_next;
      intResult_reg <= intResult_next;
      extInput_reg <= extInput_next;
      startup_reg <= startup_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      rdData_reg <= rdData_next;
      rdValid_reg <= rdValid_next;
      comp_reg <= comp_next;
      sensEn_reg <= sensEn_next;
    end
  end

  assign regRdData = rdData_reg;
  assign regRdValid = rdValid_reg;
  assign sensorEnable = sensEn_reg;
  assign compTemp = comp_reg;

  // assertions
  // host write that sets the enable bit
  sequence s_enWrite;
    regWrEn && regAddr == ADDR_CTRL && regWrData[BIT_ENABLE];
  endsequence

  // completion with no restart in the same cycle
  sequence s_doneNoRestart;
    finish && !startReq;
  endsequence

  // busy can only stand while the sensor is enabled
  a_busy_needs_enable: assert property (
    @(posedge sys_clk) disable iff (rst)
    !enable_reg |-> !busy_reg)
    else $error("busy flag set while sensor disabled");
  // enable write always opens a fresh period
  a_enable_starts_conv: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_enWrite |=> busy_reg && cnt_reg == '0)
    else $error("enable write did not start conversion");
  // disable write aborts at once
  a_disable_stops: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == ADDR_CTRL && !regWrData[BIT_ENABLE] |=> !busy_reg)
    else $error("conversion ran with sensor disabled");
  // repeat mode chains conversions
  a_repeat_restarts: assert property (
    @(posedge sys_clk) disable iff (rst)
    finish && repeat_reg && !psSync_reg && !regWrEn |=> busy_reg)
    else $error("repeat mode did not restart");
  // idle engine stays idle in power save
  a_ps_suspends: assert property (
    @(posedge sys_clk) disable iff (rst)
    !busy_reg && psSync_reg && !startup_reg && !regWrEn |=> !busy_reg)
    else $error("conversion started in power save");
  // result moves only at completion
  a_result_readonly: assert property (
    @(posedge sys_clk) disable iff (rst)
    !finish |=> $stable(intResult_reg))
    else $error("result changed outside completion");
  // stored external value always inside range
  a_ext_clamp_range: assert property (
    @(posedge sys_clk) disable iff (rst)
    $signed(extInput_reg) <= TEMP_MAX && $signed(extInput_reg) >= TEMP_MIN)
    else $error("external temperature out of range");
  // too hot a write saturates high
  a_ext_high_clamp: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == ADDR_EXT_INPUT && $signed(regWrData) > TEMP_MAX
    |=> extInput_reg == TEMP_MAX)
    else $error("high value not clamped");
  // too cold a write saturates low
  a_ext_low_clamp: assert property (
    @(posedge sys_clk) disable iff (rst)
    regWrEn && regAddr == ADDR_EXT_INPUT && $signed(regWrData) < TEMP_MIN
    |=> extInput_reg == TEMP_MIN)
    else $error("low value not clamped");
  // compensation follows the selected register
  a_comp_source: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 compTemp == (srcSel_reg ? extInput_reg : intResult_reg))
    else $error("compensation source wrong");
  // busy drops in the cycle the result lands
  a_done_together: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_doneNoRestart |=> !busy_reg && intResult_reg == $past(valSync_reg))
    else $error("busy not updated at completion");

endmodule
`default_nettype wire

/* test/ltm_sensor_model.sv */
// Purpose: behavioural analog temperature sensor
// Assumes: block samples the code while enable is high
// Notes: a disabled sensor shows the inverted code, never a stale one
`timescale 1ns/1ps
`default_nettype none
module ltm_sensor_model (
  input wire logic sys_clk,
  input wire logic sensorEnable,
  input wire logic [7:0] tempCode,
  output logic sensorDone,
  output logic [7:0] sensorValue
);
  int cnt = 0; // cycles since enable rose
  // count enabled cycles, clear when disabled
  always @(posedge sys_clk) begin
    cnt <= sensorEnable ? cnt + 1 : 0;
  end
  // three-cycle done pulse after ten enabled cycles
  assign sensorDone = sensorEnable && cnt >= 10 && cnt < 13;
  // released output carries the inverse, not the last value
  assign sensorValue = sensorEnable ? tempCode : ~tempCode;
endmodule
`default_nettype wire

/* test/tb_led_temp_measure_control.sv */
// Purpose: self-checking bench for the temperature control block
// Assumes: counter completion, ten cycles per conversion
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module tb_led_temp_measure_control;
  import ltm_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic powerSave = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, tempCode = 8'hda, d;
  wire logic [7:0] regRdData, compTemp, sensorValue;
  wire logic regRdValid, sensorEnable, sensorDone;
  int n_errors = 0, tests_run = 0;
  // written values and their saturated results
  logic [7:0] inV [7] = '{8'h7f, 8'h5a, 8'h59, 8'hda, 8'hd9, 8'h80, 8'h00};
  logic [7:0] outV [7] = '{8'h59, 8'h59, 8'h59, 8'hda, 8'hda, 8'hda, 8'h00};
  led_temp_measure_control #(.CONV_CYCLES_P(10), .USE_SENSOR_DONE(1'b0))
  i_dut (.sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .powerSave(powerSave),
    .sensorDone(sensorDone), .sensorValue(sensorValue),
    .sensorEnable(sensorEnable), .compTemp(compTemp));
  ltm_sensor_model i_sensor (.sys_clk(sys_clk), .sensorEnable(sensorEnable),
    .tempCode(tempCode), .sensorDone(sensorDone), .sensorValue(sensorValue));
  // 4 ns clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // byte compare
  task automatic chk(input logic [7:0] got, exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one write strobe
  task automatic wr(input logic [7:0] a, v);
    @(negedge sys_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge sys_clk);
    regWrEn = 1'b0;
  endtask
  // one read strobe, bounded wait for valid
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    for (int i = 0; i < 4 && regRdValid !== 1'b1; i++) @(negedge sys_clk);
    if (regRdValid !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t read valid missing", $time);
      final_report();
    end else begin
      d = regRdData;
    end
  endtask
  // read one register and compare the byte
  task automatic rd_chk(input logic [7:0] a, exp, input string msg);
    rd(a);
    chk(d, exp, msg);
  endtask
  // read until masked value matches, bounded
  task automatic poll(input logic [7:0] a, m, v);
    for (int i = 0; i < 60; i++) begin
      rd(a);
      if ((d & m) === v) return;
    end
    n_errors++;
    $display("CHECK FAILED %0t poll timeout", $time);
    final_report();
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    rd_chk(ADDR_CTRL, 8'h00, "ctrl reset");
    rd_chk(ADDR_INT_RESULT, 8'h19, "result reset");
    rd_chk(ADDR_EXT_INPUT, 8'h00, "ext reset");
    rd_chk(8'h41, 8'h00, "unmapped");
    chk(compTemp, 8'h19, "comp reset");
    wr(ADDR_INT_RESULT, 8'h55);
    rd_chk(ADDR_INT_RESULT, 8'h19, "result ro");
    $display("test reset done");
    // external input with saturation, selected source
    wr(ADDR_CTRL, 8'h01);
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_EXT_INPUT, inV[k]);
      rd_chk(ADDR_EXT_INPUT, outV[k], "clamp");
      chk(compTemp, outV[k], "comp ext");
    end
    $display("test external done");
    // single conversion
    wr(ADDR_CTRL, 8'h04);
    chk({7'h0, sensorEnable}, 8'h01, "enable");
    rd_chk(ADDR_CTRL, 8'h84, "busy");
    poll(ADDR_CTRL, 8'h80, 8'h00);
    rd_chk(ADDR_INT_RESULT, 8'hda, "result");
    chk(compTemp, 8'hda, "comp int");
    tempCode = 8'h59;
    repeat (40) @(negedge sys_clk);
    rd_chk(ADDR_INT_RESULT, 8'hda, "no rerun");
    rd_chk(ADDR_CTRL, 8'h04, "idle");
    $display("test single done");
    // continuous mode, then power save
    wr(ADDR_CTRL, 8'h06);
    poll(ADDR_INT_RESULT, 8'hff, 8'h59);
    tempCode = 8'h19;
    poll(ADDR_INT_RESULT, 8'hff, 8'h19);
    powerSave = 1'b1;
    repeat (40) @(negedge sys_clk);
    rd_chk(ADDR_CTRL, 8'h06, "suspended");
    tempCode = 8'h59;
    repeat (40) @(negedge sys_clk);
    rd_chk(ADDR_INT_RESULT, 8'h19, "held");
    powerSave = 1'b0;
    poll(ADDR_INT_RESULT, 8'hff, 8'h59);
    $display("test repeat done");
    // single mode reruns only on leaving power save
    wr(ADDR_CTRL, 8'h04);
    poll(ADDR_CTRL, 8'h80, 8'h00);
    tempCode = 8'hda;
    powerSave = 1'b1;
    repeat (20) @(negedge sys_clk);
    rd_chk(ADDR_INT_RESULT, 8'h59, "ps single held");
    powerSave = 1'b0;
    poll(ADDR_INT_RESULT, 8'hff, 8'hda);
    $display("test ps single done");
    // abort by clearing enable, busy bit not writable
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_CTRL, 8'h80);
    rd_chk(ADDR_CTRL, 8'h00, "abort");
    chk({7'h0, sensorEnable}, 8'h00, "disabled");
    $display("test abort done");
    final_report();
  end
endmodule
`default_nettype wire
